/* File: rtl/fat_regs.sv */
// Frequency alarm threshold registers with per-input alarm judgement
`timescale 1ns/1ps
`default_nettype none
`include "fat_params.svh"

// Function
// - Limit equals threshold code plus one, times 3.81 ppm.
// - Positive and negative offsets of equal size are judged alike.
// - General register: soft code in bits 7:4, hard code in 3:0.
// - Selected-source register: same layout, readable and writable.
// - The selected input is judged against the selected-source limits.
// - Soft codes reset to 0010, a window of 11.43 ppm.
// - Hard codes reset to 0011, a window of 15.24 ppm.
// - Soft and hard alarms only raised while their enables are set.
module fat_regs #(
   parameter int N_INPUTS = 14
) (
   input  wire logic               core_clk_i,
   input  wire logic               sys_rst_i,
   input  wire fat_pkg::fat_byte_t reg_addr_i,
   input  wire fat_pkg::fat_byte_t reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output fat_pkg::fat_byte_t      reg_rdata_o,
   input  wire logic               meas_valid_i,
   input  wire logic [3:0]         meas_chan_i,
   input  wire logic signed [15:0] meas_offset_i,
   input  wire logic [3:0]         sel_chan_i,
   output logic [N_INPUTS-1:0]     soft_alarm_o,
   output logic [N_INPUTS-1:0]     hard_alarm_o
);
   // ==========================================================
   // Register state
   fat_pkg::fat_byte_t  gen_reg;
   fat_pkg::fat_byte_t  gen_next;
   fat_pkg::fat_byte_t  sel_reg;
   fat_pkg::fat_byte_t  sel_next;
   logic [1:0]          en_reg;
   logic [1:0]          en_next;
   fat_pkg::fat_byte_t  rdata_reg;
   fat_pkg::fat_byte_t  rdata_next;
   fat_pkg::fat_byte_t  sts_reg;
   fat_pkg::fat_byte_t  sts_next;
   logic [N_INPUTS-1:0] soft_reg;
   logic [N_INPUTS-1:0] soft_next;
   logic [N_INPUTS-1:0] hard_reg;
   logic [N_INPUTS-1:0] hard_next;

   // Judgement signals
   logic                use_sel;
   fat_pkg::fat_code_t  soft_code;
   fat_pkg::fat_code_t  hard_code;
   logic                soft_exc;
   logic                hard_exc;
   fat_pkg::fat_mag_t   hard_lim;

   // ==========================================================
   // Register writes
   always_comb begin
      gen_next = gen_reg;
      sel_next = sel_reg;
      en_next  = en_reg;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `FAT_GEN_OFS: gen_next = reg_wdata_i;
            `FAT_SEL_OFS: sel_next = reg_wdata_i;
            `FAT_EN_OFS:  en_next  = reg_wdata_i[1:0];
            default: begin
            end
         endcase
      end
   end

   // Register reads, data one cycle later
   always_comb begin
      rdata_next = 8'h00;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `FAT_GEN_OFS: rdata_next = gen_reg;
            `FAT_SEL_OFS: rdata_next = sel_reg;
            `FAT_EN_OFS:  rdata_next = {6'h00, en_reg};
            `FAT_STS_OFS: rdata_next = sts_reg;
            default:      rdata_next = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Limit selection
   always_comb begin
      use_sel   = (meas_chan_i == sel_chan_i) && (sel_chan_i != 4'h0);
      soft_code = use_sel ? sel_reg[`FAT_SOFT_MSB:`FAT_SOFT_LSB]
                          : gen_reg[`FAT_SOFT_MSB:`FAT_SOFT_LSB];
      hard_code = use_sel ? sel_reg[`FAT_HARD_MSB:`FAT_HARD_LSB]
                          : gen_reg[`FAT_HARD_MSB:`FAT_HARD_LSB];
   end

   // Shared offset judge
   fat_limit_judge u_judge (
      .offset_i    (meas_offset_i),
      .soft_code_i (soft_code),
      .hard_code_i (hard_code),
      .soft_en_i   (en_reg[`FAT_EN_SOFT_BIT]),
      .hard_en_i   (en_reg[`FAT_EN_HARD_BIT]),
      .soft_exc_o  (soft_exc),
      .hard_exc_o  (hard_exc),
      .hard_lim_o  (hard_lim)
   );

   // Last judgement status: channel, soft, hard
   always_comb begin
      sts_next = sts_reg;
      if (meas_valid_i) begin
         sts_next = {meas_chan_i, 2'h0, soft_exc, hard_exc};
      end
   end

   // ==========================================================
   // Per-input alarm flags, each refreshed by a measurement of its own input
   generate
      for (genvar i = 0; i < N_INPUTS; i++) begin : g_flag
         always_comb begin
            soft_next[i] = soft_reg[i];
            hard_next[i] = hard_reg[i];
            if (meas_valid_i && (meas_chan_i == 4'(i + 1))) begin
               soft_next[i] = soft_exc;
               hard_next[i] = hard_exc;
            end
            else begin
               soft_next[i] = soft_reg[i] & en_reg[`FAT_EN_SOFT_BIT];
               hard_next[i] = hard_reg[i] & en_reg[`FAT_EN_HARD_BIT];
            end
         end
      end
   endgenerate

   // ==========================================================
   // State registers
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         gen_reg   <= `FAT_THR_RST;
         sel_reg   <= `FAT_THR_RST;
         en_reg    <= `FAT_EN_RST;
         rdata_reg <= 8'h00;
         sts_reg   <= 8'h00;
         soft_reg  <= '0;
         hard_reg  <= '0;
      end
      else begin
         gen_reg   <= gen_next;
         sel_reg   <= sel_next;
         en_reg    <= en_next;
         rdata_reg <= rdata_next;
         sts_reg   <= sts_next;
         soft_reg  <= soft_next;
         hard_reg  <= hard_next;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata_o  = rdata_reg;
   assign soft_alarm_o = soft_reg;
   assign hard_alarm_o = hard_reg;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Checked one edge after each reset edge, so the time-zero edge is never judged
   a_soft_reset: assert property (@(posedge core_clk_i) disable iff (1'b0)
      sys_rst_i |=> (gen_reg[7:4] == 4'h2) && (sel_reg[7:4] == 4'h2))
      else $error("soft code not 0010 after reset");

   a_hard_reset: assert property (@(posedge core_clk_i) disable iff (1'b0)
      sys_rst_i |=> (gen_reg[3:0] == 4'h3) && (sel_reg[3:0] == 4'h3))
      else $error("hard code not 0011 after reset");

   a_gen_readback: assert property (
      reg_wr_i && reg_addr_i == `FAT_GEN_OFS ##1 reg_rd_i && reg_addr_i == `FAT_GEN_OFS
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("general threshold readback wrong");

   a_sel_readback: assert property (
      reg_wr_i && reg_addr_i == `FAT_SEL_OFS ##1 reg_rd_i && reg_addr_i == `FAT_SEL_OFS
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("selected threshold readback wrong");

   a_sel_limits: assert property (
      meas_valid_i && meas_chan_i == sel_chan_i && sel_chan_i != 4'h0
      |-> hard_lim == 17'(({13'h0000, sel_reg[3:0]} + 17'h0_0001) * 17'h0_17D))
      else $error("selected input not judged on selected limits");

   a_limit_equal: assert property (
      meas_valid_i && en_reg[0] && meas_offset_i > 16'sh0000
      && 17'(meas_offset_i) == 17'(({13'h0000, hard_code} + 17'h0_0001) * 17'h0_17D)
      |=> !sts_reg[0])
      else $error("alarm raised at exactly the limit");

   a_limit_above: assert property (
      meas_valid_i && en_reg[0] && meas_offset_i > 16'sh0000
      && 17'(meas_offset_i) == 17'(({13'h0000, hard_code} + 17'h0_0001) * 17'h0_17D) + 17'h0_0001
      |=> sts_reg[0])
      else $error("alarm missing just above limit");

   a_neg_symmetric: assert property (
      meas_valid_i && en_reg[0] && meas_offset_i < -16'sh17D0
      |=> sts_reg[0])
      else $error("large negative offset not alarmed");

   a_soft_disabled: assert property (
      meas_valid_i && !en_reg[1] |=> !sts_reg[1])
      else $error("soft alarm while soft monitoring disabled");

   a_hard_disabled: assert property (
      !en_reg[0] |=> hard_alarm_o == '0)
      else $error("hard alarm while hard monitoring disabled");

   a_flag_update: assert property (
      meas_valid_i && meas_chan_i == 4'h1
      |=> hard_alarm_o[0] == sts_reg[0] && soft_alarm_o[0] == sts_reg[1])
      else $error("input flag does not follow judgement");

   c_hard_alarm:  cover property (meas_valid_i && hard_exc);
   c_soft_only:   cover property (meas_valid_i && soft_exc && !hard_exc);
   c_sel_judged:  cover property (meas_valid_i && use_sel && hard_exc);
   c_write_read:  cover property (reg_wr_i ##1 reg_rd_i);
endmodule : fat_regs
`default_nettype wire

/* File: pkg/fat_params.svh */
// Constants for the frequency alarm threshold register bank
`ifndef FAT_PARAMS_SVH
`define FAT_PARAMS_SVH

// ==========================================================
// Register offsets
`define FAT_GEN_OFS      8'h49
`define FAT_SEL_OFS      8'h4A
`define FAT_EN_OFS       8'h40
`define FAT_STS_OFS      8'h41

// ==========================================================
// Reset values
`define FAT_THR_RST      8'h23
`define FAT_EN_RST       2'h3

// ==========================================================
// Field positions
`define FAT_SOFT_MSB     7
`define FAT_SOFT_LSB     4
`define FAT_HARD_MSB     3
`define FAT_HARD_LSB     0
`define FAT_EN_SOFT_BIT  1
`define FAT_EN_HARD_BIT  0

// ==========================================================
// Limit step: 3.81 ppm in units of 0.01 ppm
`define FAT_STEP_CPPM    17'h0_17D

`endif

/* File: pkg/fat_pkg.sv */
// Types shared by the frequency alarm threshold register bank
package fat_pkg;
   // Four-bit threshold code
   typedef logic [3:0]  fat_code_t;
   // Offset magnitude and limit, units of 0.01 ppm
   typedef logic [16:0] fat_mag_t;
   // Register byte
   typedef logic [7:0]  fat_byte_t;
endpackage : fat_pkg

/* File: rtl/fat_limit_judge.sv */
// Combinational judgement of one offset against soft and hard limits
`timescale 1ns/1ps
`default_nettype none
`include "fat_params.svh"

module fat_limit_judge (
   input  wire logic signed [15:0] offset_i,
   input  wire fat_pkg::fat_code_t soft_code_i,
   input  wire fat_pkg::fat_code_t hard_code_i,
   input  wire logic               soft_en_i,
   input  wire logic               hard_en_i,
   output logic                    soft_exc_o,
   output logic                    hard_exc_o,
   output fat_pkg::fat_mag_t       hard_lim_o
);
   logic signed [16:0] off_ext;
   fat_pkg::fat_mag_t  mag;
   fat_pkg::fat_mag_t  soft_lim;

   // Magnitude so both signs judge alike
   always_comb begin
      off_ext = {offset_i[15], offset_i};
      mag     = off_ext[16] ? fat_pkg::fat_mag_t'(-off_ext) : fat_pkg::fat_mag_t'(off_ext);
   end

   // Limit is (code + 1) * 3.81 ppm
   assign soft_lim   = fat_pkg::fat_mag_t'(({13'h0000, soft_code_i} + 17'h0_0001) * `FAT_STEP_CPPM);
   assign hard_lim_o = fat_pkg::fat_mag_t'(({13'h0000, hard_code_i} + 17'h0_0001) * `FAT_STEP_CPPM);

   // Exceed only while the matching enable is set
   assign soft_exc_o = soft_en_i && (mag > soft_lim);
   assign hard_exc_o = hard_en_i && (mag > hard_lim_o);
endmodule : fat_limit_judge
`default_nettype wire

/* File: test/tb.sv */
// Self-checking testbench for the frequency alarm threshold register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
   // ==========================================================
   // Stimulus and observation signals
   logic                    core_clk_i    = 1'b0;
   logic                    sys_rst_i     = 1'b1;
   fat_pkg::fat_byte_t      reg_addr_i    = 8'h00;
   fat_pkg::fat_byte_t      reg_wdata_i   = 8'h00;
   logic                    reg_wr_i      = 1'b0;
   logic                    reg_rd_i      = 1'b0;
   fat_pkg::fat_byte_t      reg_rdata_o;
   logic                    meas_valid_i  = 1'b0;
   logic [3:0]              meas_chan_i   = 4'h0;
   logic signed [15:0]      meas_offset_i = 16'h0000;
   logic [3:0]              sel_chan_i    = 4'h0;
   logic [13:0]             soft_alarm_o;
   logic [13:0]             hard_alarm_o;
   // Bench model state
   logic [7:0]              gen_m, sel_m, en_m;
   logic [13:0]             exp_s, exp_h;
   logic                    last_s, last_h;
   int                      err_count = 0;
   int                      n_tests = 0;
   int                      cyc = 0;
   logic [3:0]              ch, sc;
   int                      off;

   fat_regs #(.N_INPUTS(14)) i_fat_regs (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .meas_valid_i(meas_valid_i), .meas_chan_i(meas_chan_i),
      .meas_offset_i(meas_offset_i), .sel_chan_i(sel_chan_i),
      .soft_alarm_o(soft_alarm_o), .hard_alarm_o(hard_alarm_o));

   // ==========================================================
   // Clock and hang guard
   initial begin
      forever #2 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         give_verdict();
      end
   end

   // ==========================================================
   // Helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Offset beyond (code+1) steps of 3.81 ppm, either sign
   function automatic logic hit(input logic [3:0] c, input int o);
      return ((o < 0) ? -o : o) > (int'(c) + 1) * 381;
   endfunction : hit
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      if (a == 8'h49) gen_m = d;
      if (a == 8'h4A) sel_m = d;
      // A cleared enable also drops the stored flags of that kind
      if (a == 8'h40) begin
         en_m  = {6'h00, d[1:0]};
         exp_s = d[1] ? exp_s : 14'h0000;
         exp_h = d[0] ? exp_h : 14'h0000;
      end
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, e);
      @(posedge core_clk_i);
      #1 chk(reg_rdata_o, 8'h00);
   endtask : rd
   // One measurement; selected input uses its own codes
   task automatic meas(input logic [3:0] c, input int o, input logic [3:0] s);
      logic [7:0] r;
      r = (c == s && s != 4'h0) ? sel_m : gen_m;
      last_s = hit(r[7:4], o);
      last_h = hit(r[3:0], o);
      if (c >= 4'h1 && c <= 4'hE) begin
         exp_s[c-1] = last_s & en_m[1];
         exp_h[c-1] = last_h & en_m[0];
      end
      @(posedge core_clk_i);
      meas_valid_i  <= 1'b1;
      meas_chan_i   <= c;
      meas_offset_i <= 16'(o);
      sel_chan_i    <= s;
      @(posedge core_clk_i);
      meas_valid_i <= 1'b0;
      #1 chk(soft_alarm_o, exp_s);
      chk(hard_alarm_o, exp_h);
   endtask : meas
   task automatic give_verdict();
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(25));
      gen_m = 8'h23;
      sel_m = 8'h23;
      en_m  = 8'h03;
      exp_s = '0;
      exp_h = '0;
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(8'h49, 8'h23);
      rd(8'h4A, 8'h23);
      rd(8'h40, 8'h03);
      rd(8'h55, 8'h00);
      // Boundaries of the reset windows, both signs
      meas(4'h3, 1600, 4'h0);
      meas(4'h3, 1524, 4'h0);
      meas(4'h3, 1525, 4'h0);
      meas(4'h3, -1524, 4'h0);
      meas(4'h3, -1525, 4'h0);
      meas(4'h2, 1143, 4'h0);
      meas(4'h2, -1144, 4'h0);
      // Selected input held to wider limits
      wr(8'h4A, 8'hFF);
      rd(8'h4A, 8'hFF);
      meas(4'h5, 1600, 4'h5);
      meas(4'h6, 1600, 4'h5);
      // Random codes, channels, offsets
      repeat (300) begin
         wr(8'h49, 8'($urandom));
         wr(8'h4A, 8'($urandom));
         ch  = 4'($urandom_range(0, 15));
         sc  = ($urandom_range(0, 1) == 1) ? ch : 4'($urandom_range(0, 15));
         off = int'($urandom_range(0, 14000)) - 7000;
         meas(ch, off, sc);
         if (ch >= 4'h1 && ch <= 4'hE) rd(8'h41, {ch, 2'b00, last_s, last_h});
      end
      // Enables off clear flags and stop new ones
      wr(8'h40, 8'h00);
      exp_s = '0;
      exp_h = '0;
      repeat (2) @(posedge core_clk_i);
      #1 chk(soft_alarm_o, 14'h0000);
      chk(hard_alarm_o, 14'h0000);
      meas(4'h3, 7000, 4'h0);
      wr(8'h40, 8'h02);
      rd(8'h40, 8'h02);
      meas(4'h4, -7000, 4'h0);
      wr(8'h40, 8'h01);
      meas(4'hE, 7000, 4'h0);
      // Mid-run reset restores thresholds and clears flags
      @(posedge core_clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      #1 chk(hard_alarm_o, 14'h0000);
      chk(soft_alarm_o, 14'h0000);
      rd(8'h49, 8'h23);
      rd(8'h4A, 8'h23);
      rd(8'h40, 8'h03);
      give_verdict();
   end
endmodule : tb

`default_nettype wire
